/* inc/rfc_params.svh */
`ifndef RFC_PARAMS_SVH
`define RFC_PARAMS_SVH
`define RFC_NUM_GLOBALS   16
`define RFC_NUM_LOCALS    16
`define RFC_NUM_FLOATS    4
`define RFC_WORD_W        32
`define RFC_FLOAT_W       80
`define RFC_CACHE_FRAMES  4
`define RFC_MAX_LOADS     3
`define RFC_FP_INDEX      15
`define RFC_FRAME_BYTES   32'h0000_0040
`define RFC_REG_RESET     32'h0000_0000
`endif

/* inc/rfc_pkg.sv */
`include "rfc_params.svh"
package rfc_pkg;
   // Address space: 0-15 globals, 16-31 current locals, 32-35 float regs
   typedef logic [5:0]  rfc_addr_t;
   typedef logic [31:0] rfc_word_t;
   typedef logic [79:0] rfc_ext_t;
   typedef logic [1:0]  rfc_slot_t;
   typedef enum logic [1:0] {RFC_IDLE, RFC_SPILL, RFC_FILL} rfc_state_t;
endpackage : rfc_pkg

/* rtl/rfc_register_file.sv */
// Summary of operation
// - Sixteen globals, four 80-bit float registers.
// - Globals untouched by calls and returns.
// - Each call on a non-full cache gets sixteen fresh locals.
// - Cache holds four local frames.
// - Full cache on call spills oldest frame.
// - Last global is stack frame pointer.
// - Load issue sets destination scoreboard bit.
// - Load data writeback clears scoreboard bit.
// - Reads of busy registers stall.
// - Unrelated instructions keep issuing, except while a spill or fill runs.
// - Up to three loads outstanding.
// - Any register usable as float operand.
`include "rfc_params.svh"
module rfc_register_file
  import rfc_pkg::*;
(
   input  wire logic             sys_clk,       // Core clock
   input  wire logic             reset,         // Async reset, high
   input  wire rfc_pkg::rfc_addr_t rd_a_addr,   // Read port A address
   input  wire rfc_pkg::rfc_addr_t rd_b_addr,   // Read port B address
   input  wire logic             rd_req,        // Instruction wants issue
   output logic [79:0]           rd_a_data,     // Port A data
   output logic [79:0]           rd_b_data,     // Port B data
   output logic                  rd_stall,      // Operand busy or frame busy
   input  wire logic             wr_en,         // Execution write
   input  wire rfc_pkg::rfc_addr_t wr_addr,     // Write address
   input  wire logic [79:0]      wr_data,       // Write data
   input  wire logic             ld_issue,      // Load issued
   input  wire rfc_pkg::rfc_addr_t ld_dest,     // Load destination
   output logic                  ld_stall,      // Scoreboard full
   input  wire logic             ld_ret,        // Load data returned
   input  wire rfc_pkg::rfc_addr_t ld_ret_addr, // Returned destination
   input  wire logic [79:0]      ld_ret_data,   // Returned data
   input  wire logic             call_req,      // Procedure call
   input  wire logic             ret_req,       // Procedure return
   output logic                  frame_busy,    // Spill or fill running
   output logic                  mem_wr,        // Stack write strobe
   output logic                  mem_rd,        // Stack read strobe
   output logic [31:0]           mem_addr,      // Stack byte address
   output logic [31:0]           mem_wdata,     // Stack write data
   input  wire logic             mem_ack,       // Stack access done
   input  wire logic [31:0]      mem_rdata,     // Stack read data
   output logic [35:0]           busy_bits      // Scoreboard view
);
   import rfc_pkg::*;

   localparam int NL = `RFC_NUM_LOCALS;
   localparam int NF = `RFC_CACHE_FRAMES;

   logic [31:0] glob  [0:`RFC_NUM_GLOBALS-1];
   logic [79:0] flt   [0:`RFC_NUM_FLOATS-1];
   logic [31:0] loc   [0:NF*NL-1];
   logic [35:0] sb;
   rfc_slot_t   cur, oldest;
   logic [2:0]  cached;
   logic [1:0]  n_out;
   rfc_state_t  state;
   logic [3:0]  word;
   rfc_slot_t   xfer_slot;

   function automatic logic [79:0] rd_fn(input rfc_addr_t a);
      logic [79:0] v;
      v = '0;
      if (a < 6'h10)
         v = {48'h0000_0000_0000, glob[a[3:0]]};
      else if (a < 6'h20)
         v = {48'h0000_0000_0000, loc[{cur, a[3:0]}]};
      else if (a < 6'h24)
         v = flt[a[1:0]];
      return v;
   endfunction : rd_fn

   wire opnd_busy = sb[rd_a_addr] | sb[rd_b_addr];
   wire sb_full   = (n_out == 2'(`RFC_MAX_LOADS));
   wire ret_take  = ld_ret & sb[ld_ret_addr];
   // Busy or missing destination refused; count stays equal to set bits
   wire dest_free = (ld_dest < 6'd36)
                    & (~sb[ld_dest] | (ret_take & (ld_ret_addr == ld_dest)));
   wire ld_take   = ld_issue & ~sb_full & (state == RFC_IDLE) & dest_free;
   wire sp_done   = (state != RFC_IDLE) & mem_ack & (word == 4'hf);
   wire need_spill = call_req & (state == RFC_IDLE) & (cached == 3'(NF));
   wire need_fill  = ret_req & (state == RFC_IDLE) & (cached == 3'd1);
   wire [1:0] next_n = n_out + 2'(ld_take) - 2'(ret_take);
   wire [31:0] fp_val = glob[`RFC_FP_INDEX];
   // Address and data lead the word count so each word stands until its ack
   wire [3:0]  next_word = (state == RFC_IDLE) ? 4'h0 : word + {3'h0, mem_ack};
   wire [31:0] next_addr = fp_val + {26'h000_0000, next_word, 2'b00};
   // Busy from the edge that leaves idle, so refusals match what is shown
   wire        next_busy = (state == RFC_IDLE) ? (need_spill | need_fill) : ~sp_done;

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         sb    <= '0;
         n_out <= '0;
      end
      else
      begin
         for (int i = 0; i < 36; i++)
            if (ld_take && ld_dest == 6'(i))
               sb[i] <= 1'b1;
            else if (ret_take && ld_ret_addr == 6'(i))
               sb[i] <= 1'b0;
         n_out <= next_n;
      end
   end

   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         for (int i = 0; i < `RFC_NUM_GLOBALS; i++)
            glob[i] <= `RFC_REG_RESET;
         for (int i = 0; i < `RFC_NUM_FLOATS; i++)
            flt[i] <= '0;
      end
      else
      begin
         if (wr_en && wr_addr < 6'h10)
            glob[wr_addr[3:0]] <= wr_data[31:0];
         if (wr_en && wr_addr >= 6'h20 && wr_addr < 6'h24)
            flt[wr_addr[1:0]] <= wr_data;
         if (ret_take && ld_ret_addr < 6'h10)
            glob[ld_ret_addr[3:0]] <= ld_ret_data[31:0];
         if (ret_take && ld_ret_addr >= 6'h20 && ld_ret_addr < 6'h24)
            flt[ld_ret_addr[1:0]] <= ld_ret_data;
      end
   end

   // Locals are memory; no reset, frames start clean on call
   always_ff @(posedge sys_clk)
   begin
      if (wr_en && wr_addr[5:4] == 2'b01)
         loc[{cur, wr_addr[3:0]}] <= wr_data[31:0];
      if (ret_take && ld_ret_addr[5:4] == 2'b01)
         loc[{cur, ld_ret_addr[3:0]}] <= ld_ret_data[31:0];
      if (state == RFC_FILL && mem_ack)
         loc[{xfer_slot, word}] <= mem_rdata;
      if (call_req && state == RFC_IDLE && cached != 3'(NF))
         for (int i = 0; i < NL; i++)
            loc[{cur + 2'd1, 4'(i)}] <= `RFC_REG_RESET;
   end

   // Frame bookkeeping; call or return while busy is ignored
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         state     <= RFC_IDLE;
         cur       <= '0;
         oldest    <= '0;
         cached    <= 3'd1;
         word      <= '0;
         xfer_slot <= '0;
      end
      else
      begin
         unique case (state)
            RFC_IDLE:
            begin
               word <= '0;
               if (need_spill)
               begin
                  state     <= RFC_SPILL;
                  xfer_slot <= oldest;
               end
               else if (need_fill)
               begin
                  state     <= RFC_FILL;
                  xfer_slot <= cur - 2'd1;
               end
               else if (call_req)
               begin
                  cur    <= cur + 2'd1;
                  cached <= cached + 3'd1;
               end
               else if (ret_req)
               begin
                  cur    <= cur - 2'd1;
                  cached <= cached - 3'd1;
               end
            end
            RFC_SPILL:
            begin
               if (mem_ack)
                  word <= word + 4'd1;
               if (sp_done)
               begin
                  state  <= RFC_IDLE;
                  oldest <= oldest + 2'd1;
                  cached <= cached - 3'd1;
               end
            end
            RFC_FILL:
            begin
               if (mem_ack)
                  word <= word + 4'd1;
               if (sp_done)
               begin
                  state  <= RFC_IDLE;
                  cur    <= cur - 2'd1;
                  oldest <= cur - 2'd1;
               end
            end
            default: state <= RFC_IDLE;
         endcase
      end
   end

   // Registered outputs
   always_ff @(posedge sys_clk or posedge reset)
   begin
      if (reset)
      begin
         rd_a_data  <= '0;
         rd_b_data  <= '0;
         rd_stall   <= 1'b0;
         ld_stall   <= 1'b0;
         frame_busy <= 1'b0;
         mem_wr     <= 1'b0;
         mem_rd     <= 1'b0;
         mem_addr   <= '0;
         mem_wdata  <= '0;
         busy_bits  <= '0;
      end
      else
      begin
         rd_a_data  <= rd_fn(rd_a_addr);
         rd_b_data  <= rd_fn(rd_b_addr);
         rd_stall   <= rd_req & (opnd_busy | (state != RFC_IDLE));
         ld_stall   <= (next_n == 2'(`RFC_MAX_LOADS));
         frame_busy <= next_busy;
         mem_wr     <= (state == RFC_SPILL) & ~sp_done;
         mem_rd     <= (state == RFC_FILL) & ~sp_done;
         mem_addr   <= next_addr;
         mem_wdata  <= loc[{xfer_slot, next_word}];
         busy_bits  <= sb;
      end
   end
endmodule : rfc_register_file

/* dv/rfc_register_file_asserts.sv */
module rfc_chk
(
   input wire logic              sys_clk,
   input wire logic              reset,
   input wire rfc_pkg::rfc_addr_t rd_a_addr,
   input wire rfc_pkg::rfc_addr_t rd_b_addr,
   input wire logic              rd_req,
   input wire logic              rd_stall,
   input wire logic              ld_issue,
   input wire rfc_pkg::rfc_addr_t ld_dest,
   input wire logic              ld_stall,
   input wire logic              ld_ret,
   input wire rfc_pkg::rfc_addr_t ld_ret_addr,
   input wire logic              frame_busy,
   input wire logic              mem_wr,
   input wire logic              mem_rd,
   input wire logic              mem_ack,
   input wire logic [31:0]       mem_addr,
   input wire logic [35:0]       busy_bits
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   // Scoreboard copy trails by a cycle; updates next to the check left out
   wire calm = !ld_issue && !ld_ret;
   sequence s_wait;
      mem_wr && !mem_ack;
   endsequence
   sequence s_step;
      mem_wr && mem_ack ##1 mem_wr;
   endsequence
   a_load_sets_bit:
   assert property (ld_issue && !ld_stall && !frame_busy |-> ##2 busy_bits[$past(ld_dest, 2)])
      else $error("load bit not set");
   a_return_clears:
   assert property (ld_ret && busy_bits[ld_ret_addr] && !(ld_issue && ld_dest == ld_ret_addr)
      |-> ##2 !busy_bits[$past(ld_ret_addr, 2)]) else $error("load bit not cleared");
   a_busy_stalls:
   assert property (rd_req && calm && $past(calm) && busy_bits[rd_a_addr] |=> rd_stall)
      else $error("busy operand not stalled");
   a_free_issues:
   assert property (rd_req && calm && $past(calm) && !frame_busy && !busy_bits[rd_a_addr]
      && !busy_bits[rd_b_addr] |=> !rd_stall) else $error("free operand stalled");
   a_three_max:
   assert property ($countones(busy_bits) <= 3) else $error("over three loads");
   a_full_flag:
   // Copy of the scoreboard shows one cycle after the full flag
   assert property ($past(ld_stall) == ($countones(busy_bits) == 3))
      else $error("ld_stall wrong");
   a_word_holds:
   assert property (s_wait |=> mem_wr && $stable(mem_addr)) else $error("word not held");
   a_addr_steps:
   assert property (s_step |-> mem_addr == $past(mem_addr) + 32'h0000_0004)
      else $error("address not stepped");
   a_strobe_busy:
   assert property ((mem_wr || mem_rd) |-> frame_busy && !(mem_wr && mem_rd))
      else $error("strobe outside transfer");
endmodule : rfc_chk
bind rfc_register_file rfc_chk i_rfc_chk (.sys_clk(sys_clk), .reset(reset),
   .rd_a_addr(rd_a_addr), .rd_b_addr(rd_b_addr), .rd_req(rd_req), .rd_stall(rd_stall),
   .ld_issue(ld_issue), .ld_dest(ld_dest), .ld_stall(ld_stall), .ld_ret(ld_ret),
   .ld_ret_addr(ld_ret_addr), .frame_busy(frame_busy), .mem_wr(mem_wr), .mem_rd(mem_rd),
   .mem_ack(mem_ack), .mem_addr(mem_addr), .busy_bits(busy_bits));

/* dv/rfc_mem_model.sv */
module rfc_mem_model
(
   input  wire logic        sys_clk,   // Core clock
   input  wire logic        mem_wr,    // Write strobe
   input  wire logic        mem_rd,    // Read strobe
   input  wire logic [31:0] mem_addr,  // Byte address
   input  wire logic [31:0] mem_wdata, // Write data
   input  wire logic [1:0]  dly,       // Wait states
   output logic             mem_ack,   // Word done
   output logic [31:0]      mem_rdata  // Read data
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [31:0] m [0:255];
   logic [1:0]  cnt = 2'h0;
   wire  [7:0]  ix = mem_addr[9:2];
   assign mem_ack = (mem_wr || mem_rd) && cnt == dly;
   // Idle bus shows inverted data, never a stale match
   assign mem_rdata = mem_rd ? m[ix] : ~m[ix];
   always @(posedge sys_clk)
   begin
      cnt <= (mem_ack || !(mem_wr || mem_rd)) ? 2'h0 : cnt + 2'h1;
      if (mem_ack && mem_wr) m[ix] <= mem_wdata;
   end
endmodule : rfc_mem_model

/* dv/rfc_register_file_tb.sv */
`define CHK(n, e, s) begin checked++; if ((e) !== (s)) begin n_errors++; \
   $display("[ERR] %s exp %h got %h", n, e, s); end end
module rfc_register_file_tb;
   timeunit 1ns;
   timeprecision 100ps;
   import rfc_pkg::*;
   logic        sys_clk = 1'b0, reset = 1'b1, rd_req = 1'b0, wr_en = 1'b0;
   logic        ld_issue = 1'b0, ld_ret = 1'b0, call_req = 1'b0, ret_req = 1'b0;
   logic        rd_stall, ld_stall, frame_busy, mem_wr, mem_rd, mem_ack;
   rfc_addr_t   rd_a_addr = 6'h00, rd_b_addr = 6'h00, wr_addr = 6'h00;
   rfc_addr_t   ld_dest = 6'h00, ld_ret_addr = 6'h00;
   rfc_ext_t    wr_data = 80'h0, ld_ret_data = 80'h0, rd_a_data, rd_b_data, e;
   rfc_ext_t    mv [0:35];
   logic [31:0] mem_addr, mem_wdata, mem_rdata, first;
   logic [35:0] busy_bits;
   logic [80:0] x, q [$];
   logic [1:0]  dly = 2'h0;
   int          n_errors = 0, checked = 0, cyc = 0, words = 0, seed = 32'h3ee6_90d0;
   rfc_register_file i_rfc_register_file (.sys_clk(sys_clk), .reset(reset),
      .rd_a_addr(rd_a_addr), .rd_b_addr(rd_b_addr), .rd_req(rd_req), .rd_a_data(rd_a_data),
      .rd_b_data(rd_b_data), .rd_stall(rd_stall), .wr_en(wr_en), .wr_addr(wr_addr),
      .wr_data(wr_data), .ld_issue(ld_issue), .ld_dest(ld_dest), .ld_stall(ld_stall),
      .ld_ret(ld_ret), .ld_ret_addr(ld_ret_addr), .ld_ret_data(ld_ret_data),
      .call_req(call_req), .ret_req(ret_req), .frame_busy(frame_busy), .mem_wr(mem_wr),
      .mem_rd(mem_rd), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata), .busy_bits(busy_bits));
   rfc_mem_model i_rfc_mem_model (.sys_clk(sys_clk), .mem_wr(mem_wr), .mem_rd(mem_rd),
      .mem_addr(mem_addr), .mem_wdata(mem_wdata), .dly(dly), .mem_ack(mem_ack),
      .mem_rdata(mem_rdata));
   always #5 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (++cyc == 20000) begin n_errors++; conclude(); end
   always @(posedge sys_clk) if (mem_ack && (mem_wr || mem_rd))
   begin
      if (words == 0) first = mem_addr;
      words++;
   end
   always @(negedge sys_clk) if (q.size() != 0)
   begin
      x = q.pop_front();
      `CHK("rd_stall", x[80], rd_stall)
      if (!x[80]) `CHK("rd_a_data", x[79:0], rd_a_data)
      if (!x[80]) `CHK("rd_b_data", x[79:0], rd_b_data)
   end
   task conclude;
      $display("checked %0d n_errors %0d", checked, n_errors);
      if (n_errors == 0 && checked > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : conclude
   task tick; @(posedge sys_clk); #1; endtask : tick
   // Strobes stay up for back-to-back use until rest
   task rest; {rd_req, wr_en, ld_issue, ld_ret} = 4'h0; tick(); endtask : rest
   task automatic rd(input rfc_addr_t a, input logic s, input rfc_ext_t d);
      {rd_a_addr, rd_b_addr, rd_req} = {a, a, 1'b1};
      @(posedge sys_clk);
      q.push_back({s, d});
      #1;
   endtask : rd
   task automatic wr(input rfc_addr_t a, input rfc_ext_t d);
      {wr_addr, wr_data, wr_en} = {a, d, 1'b1};
      mv[a] = a < 6'h20 ? {48'h0, d[31:0]} : d;
      tick();
   endtask : wr
   task automatic ld(input rfc_addr_t a); {ld_dest, ld_issue} = {a, 1'b1}; tick(); endtask : ld
   task automatic ldr(input rfc_addr_t a, input logic k);
      e = 80'({$random(seed), $random(seed), $random(seed)});
      {ld_ret_addr, ld_ret_data, ld_ret} = {a, e, 1'b1};
      if (k) mv[a] = {48'h0, e[31:0]};
      tick();
   endtask : ldr
   task automatic pulse(ref logic s);
      int i;
      s = 1'b1;
      tick();
      s = 1'b0;
      i = 0;
      do tick(); while (frame_busy !== 1'b0 && ++i < 300);
   endtask : pulse
   initial
   begin
      repeat (6) @(posedge sys_clk);
      #1 reset = 1'b0;
      `CHK("busy_bits", 36'h0_0000_0000, busy_bits)
      rd(6'h03, 1'b0, 80'h0);
      for (int r = 0; r < 36; r++) wr(6'(r), 80'({$random(seed), $random(seed), $random(seed)}));
      for (int r = 0; r < 36; r++) rd(6'(r), 1'b0, mv[r]);
      rest();
      ld(6'h04); ld(6'h05); ld(6'h14); ld(6'h06); rest();
      `CHK("busy_bits", 36'h0_0010_0030, busy_bits)
      `CHK("ld_stall", 1'b1, ld_stall)
      rd(6'h04, 1'b1, 80'h0); rd(6'h07, 1'b0, mv[7]); rest();
      ldr(6'h04, 1'b1); rest();
      `CHK("ld_stall", 1'b0, ld_stall)
      rd(6'h04, 1'b0, mv[4]); ldr(6'h05, 1'b1); ldr(6'h14, 1'b1); ldr(6'h07, 1'b0); rest();
      `CHK("busy_bits", 36'h0_0000_0000, busy_bits)
      rd(6'h07, 1'b0, mv[7]); wr(6'h0f, 80'h0000_0100); rest();
      for (int i = 0; i < 3; i++) pulse(call_req);
      `CHK("spill_words", 0, words)
      rd(6'h10, 1'b0, 80'h0); rest();
      dly = 2'h2;
      pulse(call_req);
      `CHK("spill_words", 16, words)
      `CHK("spill_base", mv[15][31:0], first)
      pulse(call_req);
      rd(6'h10, 1'b0, 80'h0); rd(6'h01, 1'b0, mv[1]); rest();
      {words, dly} = {0, 2'h0};
      for (int i = 0; i < 3; i++) pulse(ret_req);
      `CHK("fill_words", 0, words)
      pulse(ret_req);
      `CHK("fill_words", 16, words)
      for (int r = 16; r < 32; r++) rd(6'(r), 1'b0, mv[r]);
      rest();
      conclude();
   end
endmodule : rfc_register_file_tb
